// File: src/serial_port_control.sv
`timescale 1ns/10ps
module serial_port_control
	import serial_port_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxd_in,
	output logic             rxd_out,
	output logic             rxd_oe,
	output logic             txd_out,
	output logic             txd_oe,
	input  wire logic        txd_in,
	output logic             irq
);

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0]   control_ff;
	logic [7:0]   option_ff;
	logic         baud_double_ff;
	logic [7:0]   reload_ff;
	logic [7:0]   rx_buf_ff;
	logic [1:0]   irq_mask_ff;
	logic [31:0]  prdata_ff;
	serial_mode_t mode;
	logic         wr_acc;
	logic         rd_acc;
	logic         hit;
	logic         tx_set;
	logic         rx_set;
	logic         rx_ninth_set;
	logic         rx_ninth_val;

	assign mode    = serial_mode_t'({control_ff[SC_MODE_HI],
		control_ff[SC_MODE_LO]});
	assign wr_acc  = psel && penable && pwrite;
	assign rd_acc  = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign hit     = (paddr == OPTION_CONTROL_OFF) ||
		(paddr == SERIAL_CONTROL_OFF) || (paddr == SERIAL_BUFFER_OFF) ||
		(paddr == POWER_CONTROL_OFF) || (paddr == BAUD_RELOAD_OFF) ||
		(paddr == IRQ_STATUS_OFF) || (paddr == IRQ_MASK_OFF);
	assign pslverr = psel && penable && !hit;
	assign prdata  = prdata_ff;

	// Flags live in the control register; status mirrors them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control_ff <= SERIAL_CONTROL_RST;
		end else begin
			if (wr_acc && paddr == SERIAL_CONTROL_OFF) begin
				control_ff <= pwdata[7:0];
			end
			if (wr_acc && paddr == IRQ_STATUS_OFF) begin
				if (pwdata[IRQ_TX_BIT]) begin
					control_ff[SC_TX_DONE] <= 1'b0;
				end
				if (pwdata[IRQ_RX_BIT]) begin
					control_ff[SC_RX_DONE] <= 1'b0;
				end
			end
			if (rx_ninth_set) begin
				control_ff[SC_RX_NINTH] <= rx_ninth_val;
			end
			// Set wins over a same-cycle software clear
			if (tx_set) begin
				control_ff[SC_TX_DONE] <= 1'b1;
			end
			if (rx_set) begin
				control_ff[SC_RX_DONE] <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			option_ff      <= OPTION_CONTROL_RST;
			baud_double_ff <= 1'b0;
			reload_ff      <= BAUD_RELOAD_RST;
			irq_mask_ff    <= 2'h0;
		end else if (wr_acc) begin
			case (paddr)
				OPTION_CONTROL_OFF: option_ff <= pwdata[7:0];
				POWER_CONTROL_OFF: baud_double_ff <= pwdata[PWR_BAUD_DBL];
				BAUD_RELOAD_OFF: reload_ff <= pwdata[7:0];
				IRQ_MASK_OFF: irq_mask_ff <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				OPTION_CONTROL_OFF: prdata_ff <= {24'h0, option_ff};
				SERIAL_CONTROL_OFF: prdata_ff <= {24'h0, control_ff};
				SERIAL_BUFFER_OFF: prdata_ff <= {24'h0, rx_buf_ff};
				POWER_CONTROL_OFF: prdata_ff <= {24'h0, baud_double_ff,
					7'h0};
				BAUD_RELOAD_OFF: prdata_ff <= {24'h0, reload_ff};
				IRQ_STATUS_OFF: prdata_ff <= {30'h0,
					control_ff[SC_TX_DONE], control_ff[SC_RX_DONE]};
				IRQ_MASK_OFF: prdata_ff <= {30'h0, irq_mask_ff};
				default: prdata_ff <= 32'h0;
			endcase
		end
	end

	assign irq = |(irq_mask_ff &
		{control_ff[SC_TX_DONE], control_ff[SC_RX_DONE]});

	// ****************************************
	// Baud tick
	// ****************************************
	logic [15:0] div;
	logic [15:0] div_cnt_ff;
	logic        tick;
	logic [15:0] var_div;

	// Doubling halves the oversampled period
	assign var_div = baud_double_ff ? ({8'h0, reload_ff} + 16'h1)
		: (({8'h0, reload_ff} + 16'h1) << 1);

	always_comb begin
		case (mode)
			MODE_SHIFT: div = SHIFT_DIV;
			MODE_UART9_FIXED: div = (baud_double_ff ? FIXED_DIV_FAST
				: FIXED_DIV_SLOW) / VAR_DIV_UNIT;
			default: div = var_div;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_ff <= 16'h0;
		end else if (div_cnt_ff + 16'h1 >= div) begin
			div_cnt_ff <= 16'h0;
		end else begin
			div_cnt_ff <= div_cnt_ff + 16'h1;
		end
	end
	// UART ticks run at 16x; shift mode ticks twice per bit, once per clock phase
	assign tick = (div_cnt_ff + 16'h1 >= div);

	// ****************************************
	// Transmitter
	// ****************************************
	logic [9:0] tx_sh_ff;
	logic [3:0] tx_bits_ff;
	logic [3:0] tx_os_ff;
	logic       tx_busy_ff;
	logic       tx_line_ff;
	logic       tx_clk_ff;
	logic       tx_start;
	logic [3:0] frame_len;
	frame_t     tx_frame;

	assign tx_frame  = '{data: pwdata[7:0],
		ninth: control_ff[SC_TX_NINTH]};
	assign tx_start  = wr_acc && paddr == SERIAL_BUFFER_OFF &&
		!tx_busy_ff;
	assign frame_len = (mode == MODE_UART8) ? 4'd9 : 4'd10;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_sh_ff   <= 10'h3ff;
			tx_bits_ff <= 4'h0;
			tx_os_ff   <= 4'h0;
			tx_busy_ff <= 1'b0;
			tx_line_ff <= 1'b1;
			tx_clk_ff  <= 1'b1;
		end else if (tx_start) begin
			tx_busy_ff <= 1'b1;
			tx_bits_ff <= 4'h0;
			tx_os_ff   <= 4'h0;
			if (mode == MODE_SHIFT) begin
				tx_sh_ff <= {2'b11, tx_frame.data};
			end else if (mode == MODE_UART8) begin
				tx_sh_ff <= {1'b1, 1'b1, tx_frame.data};
				tx_line_ff <= 1'b0;
			end else begin
				tx_sh_ff <= {1'b1, tx_frame.ninth, tx_frame.data};
				tx_line_ff <= 1'b0;
			end
		end else if (tx_busy_ff && tick) begin
			if (mode == MODE_SHIFT) begin
				// Data changes on the low phase, sampled on the rise;
				// the last bit is held a half period past its rise
				if (tx_clk_ff && tx_bits_ff == 4'd8) begin
					tx_busy_ff <= 1'b0;
					tx_line_ff <= 1'b1;
				end else if (tx_clk_ff) begin
					tx_clk_ff  <= 1'b0;
					tx_line_ff <= tx_sh_ff[0];
					tx_sh_ff   <= {1'b1, tx_sh_ff[9:1]};
				end else begin
					tx_clk_ff  <= 1'b1;
					tx_bits_ff <= tx_bits_ff + 4'h1;
				end
			end else begin
				tx_os_ff <= tx_os_ff + 4'h1;
				if (tx_os_ff == 4'hf) begin
					if (tx_bits_ff == frame_len) begin
						tx_busy_ff <= 1'b0;
					end else begin
						tx_line_ff <= tx_sh_ff[0];
						tx_sh_ff   <= {1'b1, tx_sh_ff[9:1]};
						tx_bits_ff <= tx_bits_ff + 4'h1;
					end
				end
			end
		end
	end

	assign tx_set = tx_busy_ff && tick && ((mode == MODE_SHIFT) ?
		(!tx_clk_ff && tx_bits_ff == 4'd7) :
		(tx_os_ff == 4'hf && tx_bits_ff + 4'h1 == frame_len));

	// ****************************************
	// Pins
	// ****************************************
	logic rx_line;

	always_comb begin
		rxd_out = 1'b1;
		rxd_oe  = 1'b0;
		txd_out = tx_line_ff;
		txd_oe  = 1'b1;
		rx_line = rxd_in;
		if (mode == MODE_SHIFT) begin
			// Shift mode drives data on rxd and the clock on txd
			rxd_out = tx_line_ff;
			rxd_oe  = tx_busy_ff;
			txd_out = tx_clk_ff;
		end else if (option_ff[OPT_ONE_WIRE]) begin
			rx_line = txd_in;
			txd_oe  = tx_busy_ff;
		end
	end

	// ****************************************
	// Receiver
	// ****************************************
	logic [8:0] rx_sh_ff;
	logic [3:0] rx_bits_ff;
	logic [3:0] rx_os_ff;
	logic       rx_busy_ff;
	logic       rx_enable;
	logic       rx_stop_pt;
	logic       rx_accept;

	assign rx_enable  = control_ff[SC_RX_ENABLE];
	// Stop sample follows the last data or ninth bit
	assign rx_stop_pt = rx_busy_ff && rx_enable && tick &&
		mode != MODE_SHIFT && rx_os_ff == MID_SAMPLE - 4'h1 &&
		rx_bits_ff == frame_len;

	always_comb begin
		rx_accept = 1'b1;
		if (mode == MODE_UART8 && control_ff[SC_MP_FILTER]) begin
			rx_accept = rx_line;
		end else if (mode != MODE_SHIFT && mode != MODE_UART8 &&
			control_ff[SC_MP_FILTER]) begin
			rx_accept = rx_sh_ff[8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_sh_ff   <= 9'h0;
			rx_bits_ff <= 4'h0;
			rx_os_ff   <= 4'h0;
			rx_busy_ff <= 1'b0;
			rx_buf_ff  <= 8'h0;
		end else if (!rx_busy_ff) begin
			rx_bits_ff <= 4'h0;
			rx_os_ff   <= 4'h0;
			if (rx_enable && mode != MODE_SHIFT && !rx_line) begin
				rx_busy_ff <= 1'b1;
			end
		end else if (!rx_enable) begin
			rx_busy_ff <= 1'b0;
		end else if (tick && mode != MODE_SHIFT) begin
			rx_os_ff <= rx_os_ff + 4'h1;
			if (rx_os_ff == MID_SAMPLE - 4'h1) begin
				if (rx_bits_ff == 4'h0 && rx_line) begin
					rx_busy_ff <= 1'b0;
				end else if (rx_stop_pt) begin
					rx_busy_ff <= 1'b0;
					if (rx_accept) begin
						rx_buf_ff <= (mode == MODE_UART8) ?
							rx_sh_ff[8:1] : rx_sh_ff[7:0];
					end
				end else begin
					if (rx_bits_ff != 4'h0) begin
						rx_sh_ff <= {rx_line, rx_sh_ff[8:1]};
					end
					rx_bits_ff <= rx_bits_ff + 4'h1;
				end
			end
		end
	end

	assign rx_set       = rx_stop_pt && rx_accept;
	assign rx_ninth_set = rx_set;
	assign rx_ninth_val = (mode == MODE_UART8) ? rx_line : rx_sh_ff[8];

	// ****************************************
	// Checks
	// ****************************************
	tx_done_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_set |=> control_ff[SC_TX_DONE])
		else $error("transmit done flag not set");
	rx_filter_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rx_stop_pt && (mode == MODE_UART9_FIXED ||
		mode == MODE_UART9_VAR) && control_ff[SC_MP_FILTER]
		&& !rx_sh_ff[8]) |-> !rx_set)
		else $error("filtered frame raised receive flag");
	rx_enable_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!rx_enable && !rx_busy_ff) |=> !rx_busy_ff)
		else $error("receiver started while disabled");
	rx_off_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!rx_enable |-> !rx_set)
		else $error("receive flag raised while disabled");
	tx_busy_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_acc && paddr == SERIAL_BUFFER_OFF && tx_busy_ff) |=>
		tx_busy_ff)
		else $error("busy transmitter restarted");
	flag_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
		($past(control_ff[SC_RX_DONE]) && !$past(wr_acc)) |->
		control_ff[SC_RX_DONE])
		else $error("receive flag cleared by hardware");

endmodule

// File: src/serial_port_pkg.sv
package serial_port_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [11:0] OPTION_CONTROL_OFF = 12'h094;
	localparam logic [11:0] SERIAL_CONTROL_OFF = 12'h098;
	localparam logic [11:0] SERIAL_BUFFER_OFF  = 12'h099;
	localparam logic [11:0] POWER_CONTROL_OFF  = 12'h087;
	localparam logic [11:0] BAUD_RELOAD_OFF    = 12'h0a0;
	localparam logic [11:0] IRQ_STATUS_OFF     = 12'h0a4;
	localparam logic [11:0] IRQ_MASK_OFF       = 12'h0a8;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int SC_MODE_HI   = 7;
	localparam int SC_MODE_LO   = 6;
	localparam int SC_MP_FILTER = 5;
	localparam int SC_RX_ENABLE = 4;
	localparam int SC_TX_NINTH  = 3;
	localparam int SC_RX_NINTH  = 2;
	localparam int SC_TX_DONE   = 1;
	localparam int SC_RX_DONE   = 0;
	localparam int OPT_ONE_WIRE = 3;
	localparam int PWR_BAUD_DBL = 7;
	localparam int IRQ_TX_BIT   = 1;
	localparam int IRQ_RX_BIT   = 0;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [7:0]  SERIAL_CONTROL_RST = 8'h00;
	localparam logic [7:0]  OPTION_CONTROL_RST = 8'h00;
	localparam logic [7:0]  BAUD_RELOAD_RST    = 8'h00;
	localparam logic [15:0] SHIFT_DIV          = 16'h0001;
	localparam logic [15:0] FIXED_DIV_FAST     = 16'h0020;
	localparam logic [15:0] FIXED_DIV_SLOW     = 16'h0040;
	localparam logic [15:0] VAR_DIV_UNIT       = 16'h0010;
	localparam logic [3:0]  MID_SAMPLE         = 4'h8;

	typedef enum logic [1:0] {
		MODE_SHIFT,
		MODE_UART8,
		MODE_UART9_FIXED,
		MODE_UART9_VAR
	} serial_mode_t;

	typedef struct packed {
		logic [7:0] data;
		logic       ninth;
	} frame_t;

endpackage

// File: test/remote_serial.sv
`timescale 1ns/10ps
module remote_serial (
	input  wire logic clk,
	input  wire logic line_in,
	output logic      line_out
);
	// ****************************************
	// Far-side serial device
	// ****************************************
	// Idle line rests at mark level, as the pull-up would leave it
	initial line_out = 1'b1;

	// Start, data LSB first, then a stop bit of the chosen level
	task automatic send(input logic [8:0] f, input int nb, input int bt,
		input logic stp);
		line_out <= 1'b0;
		repeat (bt) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			line_out <= f[i];
			repeat (bt) @(posedge clk);
		end
		line_out <= stp;
		repeat (bt) @(posedge clk);
		line_out <= 1'b1;
		repeat (bt) @(posedge clk);
	endtask

	// Samples each bit in its middle; the bench timeout ends a dead line
	task automatic recv(input int nb, input int bt, output logic [8:0] f);
		f = '0;
		while (line_in !== 1'b0) @(posedge clk);
		repeat (bt / 2) @(posedge clk);
		for (int i = 0; i < nb; i++) begin
			repeat (bt) @(posedge clk);
			f[i] = line_in;
		end
	endtask
endmodule

// File: test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	import serial_port_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, one_wire, prev;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, rxd_out, rxd_oe, txd_out, txd_oe, irq;
	logic        peer_tx, serr;
	logic [8:0]  fr;
	wire         txd_pin = txd_oe ? txd_out : peer_tx;
	int          err_total, check_count, cyc, k;
	logic [7:0]  tc[5] = '{8'h88, 8'hc0, 8'h88, 8'hc8, 8'h40};
	logic [7:0]  tp[5] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h80};
	logic [7:0]  tr[5] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h02};
	int          tb[5] = '{32, 16, 64, 64, 48};
	logic        tn[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

	serial_port_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxd_in(one_wire ? 1'b1 : peer_tx), .rxd_out(rxd_out),
		.rxd_oe(rxd_oe), .txd_out(txd_out), .txd_oe(txd_oe),
		.txd_in(txd_pin), .irq(irq));
	remote_serial PEER (.clk(pclk), .line_in(txd_pin), .line_out(peer_tx));

	always #5 pclk = ~pclk;

	// ****************************************
	// Bus and check tasks
	// ****************************************
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk) penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [7:0] e,
		input string n);
		apb(1'b0, a, 8'h00);
		chk(n, {24'h000000, e}, rd);
	endtask

	task automatic irqchk(input logic e);
		repeat (2) @(posedge pclk);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask

	task automatic rx(input logic [7:0] ctl, input logic [8:0] f,
		input int nb, input logic stp, input logic [7:0] e);
		apb(1'b1, SERIAL_CONTROL_OFF, ctl);
		PEER.send(f, nb, (nb == 9) ? 32 : 16, stp);
		rdchk(SERIAL_CONTROL_OFF, e, "control");
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			results();
		end
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = '0; pwdata = '0; one_wire = 0; prev = 0;
		err_total = 0; check_count = 0; cyc = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdchk(SERIAL_CONTROL_OFF, SERIAL_CONTROL_RST, "control rst");
		rdchk(OPTION_CONTROL_OFF, OPTION_CONTROL_RST, "option rst");
		rdchk(12'h00c, 8'h00, "unmapped");
		chk("slverr", 32'h1, {31'h0, serr});
		$display("test reset done");
		apb(1'b1, POWER_CONTROL_OFF, 8'h80);
		apb(1'b1, IRQ_MASK_OFF, 8'h03);
		rx(8'h90, 9'h13c, 9, 1'b1, 8'h95);
		rdchk(SERIAL_BUFFER_OFF, 8'h3c, "rx data");
		irqchk(1'b1);
		apb(1'b1, IRQ_MASK_OFF, 8'h02);
		irqchk(1'b0);
		apb(1'b1, IRQ_MASK_OFF, 8'h03);
		apb(1'b1, IRQ_STATUS_OFF, 8'h01);
		irqchk(1'b0);
		rx(8'hb0, 9'h03c, 9, 1'b1, 8'hb0);
		rx(8'hb0, 9'h1c3, 9, 1'b1, 8'hb5);
		rx(8'h80, 9'h1c3, 9, 1'b1, 8'h80);
		rx(8'h50, 9'h077, 8, 1'b1, 8'h55);
		rx(8'h70, 9'h077, 8, 1'b0, 8'h70);
		$display("test receive done");
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, POWER_CONTROL_OFF, tp[i]);
			apb(1'b1, BAUD_RELOAD_OFF, tr[i]);
			apb(1'b1, SERIAL_CONTROL_OFF, tc[i]);
			apb(1'b1, SERIAL_BUFFER_OFF, 8'h5a ^ i[7:0]);
			// Second write lands mid-frame and must not disturb it
			apb(1'b1, SERIAL_BUFFER_OFF, 8'hff);
			PEER.recv(9, tb[i], fr);
			// Flag sets at the stop bit; let the frame finish first
			repeat (2 * tb[i]) @(posedge pclk);
			chk("tx frame", {23'h0, tn[i], 8'h5a ^ i[7:0]},
				{23'h0, fr});
			rdchk(SERIAL_CONTROL_OFF, tc[i] | 8'h02, "tx done");
			irqchk(1'b1);
			apb(1'b1, IRQ_STATUS_OFF, 8'h02);
			irqchk(1'b0);
		end
		$display("test transmit done");
		apb(1'b1, OPTION_CONTROL_OFF, 8'h08);
		one_wire <= 1'b1;
		irqchk(1'b0);
		chk("txd_oe idle", 32'h0, {31'h0, txd_oe});
		rx(8'h90, 9'h1a6, 9, 1'b1, 8'h95);
		rdchk(SERIAL_BUFFER_OFF, 8'ha6, "one wire data");
		apb(1'b1, OPTION_CONTROL_OFF, 8'h00);
		one_wire <= 1'b0;
		$display("test one wire done");
		apb(1'b1, SERIAL_CONTROL_OFF, 8'h00);
		apb(1'b1, SERIAL_BUFFER_OFF, 8'h96);
		k = 0;
		fr = '0;
		// Shift clock idles high, so no edge before the first fall
		prev = 1'b1;
		for (int c = 0; c < 300 && k < 8; c++) begin
			@(posedge pclk);
			if (txd_out === 1'b1 && prev === 1'b0) begin
				fr[k] = rxd_out;
				chk("rxd_oe", 32'h1, {31'h0, rxd_oe});
				k++;
			end
			prev = txd_out;
		end
		chk("shift data", 32'h96, {23'h0, fr});
		$display("test shift done");
		results();
	end
endmodule
